// File: rtl/esmb_defs.svh
// Purpose: Timing counts and field sizes for the expansion slot host controller
// Assumes: Clock of 250 MHz (4 ns period)
// Notes:   Times are held in their own unit, cycle counts are derived from them
`ifndef ESMB_DEFS_SVH
`define ESMB_DEFS_SVH

`define ESMB_CLK_PERIOD_PS   4000
`define ESMB_RESET_HOLD_MS   30
`define ESMB_RESET_HOLD_CYC  ((`ESMB_RESET_HOLD_MS * 1000000) / (`ESMB_CLK_PERIOD_PS / 1000))
`define ESMB_POWER_GOOD_MS   5
`define ESMB_ADDR_SETUP_NS   55
`define ESMB_ADDR_SETUP_CYC  (((`ESMB_ADDR_SETUP_NS * 1000) + `ESMB_CLK_PERIOD_PS - 1) / `ESMB_CLK_PERIOD_PS)
`define ESMB_STROBE_NS       125
`define ESMB_STROBE_CYC      (((`ESMB_STROBE_NS * 1000) + `ESMB_CLK_PERIOD_PS - 1) / `ESMB_CLK_PERIOD_PS)
`define ESMB_WE_LEAD_NS      25
`define ESMB_WE_LEAD_CYC     (((`ESMB_WE_LEAD_NS * 1000) + `ESMB_CLK_PERIOD_PS - 1) / `ESMB_CLK_PERIOD_PS)
`define ESMB_HOLD_NS         35
`define ESMB_HOLD_CYC        (((`ESMB_HOLD_NS * 1000) + `ESMB_CLK_PERIOD_PS - 1) / `ESMB_CLK_PERIOD_PS)
`define ESMB_ADDR_W          24
`define ESMB_DATA_W          16
`define ESMB_CNT_W           24

`endif

// File: rtl/esmb_pkg.sv
// Purpose: Types shared by the expansion slot host controller
// Assumes: Nothing
// Notes:   Counts and widths live in esmb_defs.svh
package esmb_pkg;
    // Bus sequencer states
    typedef enum logic [2:0] {
        ESMB_IDLE  = 3'b000,
        ESMB_SETUP = 3'b001,
        ESMB_STRB  = 3'b010,
        ESMB_LEAD  = 3'b011,
        ESMB_HOLD  = 3'b100
    } esmb_state_t;
endpackage

// File: rtl/esmb_power.sv
// Purpose: Slot power and slot reset sequencing from the seat detects
// Assumes: Seat detects already synchronised by the caller
// Notes:   Software reset restarts the hold window
`timescale 1ns/1ps
`include "esmb_defs.svh"

module esmb_power #(
    parameter int RESET_HOLD_CYC = `ESMB_RESET_HOLD_CYC
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_srst,
    // Control
    input  wire logic i_seated,
    input  wire logic i_sw_reset,
    // Status
    output logic      o_power_on,
    output logic      o_slot_reset_n,
    output logic      o_ready
);
    logic [`ESMB_CNT_W-1:0] cnt_reg;     // Reset window counter
    logic [`ESMB_CNT_W-1:0] cnt_next;
    logic                   pwr_reg;     // Slot power enable
    logic                   rst_n_reg;   // Slot reset, low = asserted
    logic                   done;        // Hold window elapsed

    assign done = (cnt_reg == RESET_HOLD_CYC[`ESMB_CNT_W-1:0]);
    // Count while seated and no software reset; restart on either
    assign cnt_next = (!i_seated || i_sw_reset) ? '0 :
                      (done ? cnt_reg : cnt_reg + 1'b1);

    // Power follows seating; reset held until the window elapses
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            cnt_reg   <= '0;
            pwr_reg   <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            pwr_reg   <= i_seated;
            rst_n_reg <= i_seated && !i_sw_reset && done;
        end
    end

    assign o_power_on     = pwr_reg;
    assign o_slot_reset_n = rst_n_reg;
    assign o_ready        = rst_n_reg;

    // Power may only follow a seated slot of the previous cycle
    property p_power_needs_seat;
        @(posedge i_ref_clk) disable iff (i_srst)
        o_power_on |-> $past(i_seated);
    endproperty
    a_power_needs_seat: assert property (p_power_needs_seat) else $error("power on without seat");

    // Unseating pulls the slot reset low on the next cycle
    property p_unseated_resets;
        @(posedge i_ref_clk) disable iff (i_srst)
        !i_seated |=> !o_slot_reset_n;
    endproperty
    a_unseated_resets: assert property (p_unseated_resets) else $error("reset free unseated");
endmodule

// File: rtl/esmb_host.sv
// Purpose: Host controller driving an expansion slot memory bus
// Assumes: One requester; strobes are generated from the 250 MHz clock
// Notes:   Slot pins are active low except power on, as on the connector
// Function
// - Address stable before and through read strobe
// - Write strobe held high during reads
// - Slot reset held 30 ms after insertion
// - Power off until both seat detects asserted
// - Data and address valid before write strobe
// - Write strobe rises before select releases
// - Read strobe held high during writes
// - Only one region select per access
`timescale 1ns/1ps
`include "esmb_defs.svh"

module esmb_host #(
    parameter int RESET_HOLD_CYC = `ESMB_RESET_HOLD_CYC
) (
    // Clock and reset
    input  wire logic                    I_REF_CLK,
    input  wire logic                    I_SRST,
    // User request
    input  wire logic                    I_REQ_VALID,
    input  wire logic                    I_REQ_WRITE,
    input  wire logic                    I_REQ_REGION,
    input  wire logic [`ESMB_ADDR_W-1:0] I_REQ_ADDR,
    input  wire logic [`ESMB_DATA_W-1:0] I_REQ_WDATA,
    input  wire logic                    I_SW_RESET,
    output logic                         O_REQ_READY,
    output logic                         O_RSP_VALID,
    output logic [`ESMB_DATA_W-1:0]      O_RSP_RDATA,
    output logic                         O_SLOT_READY,
    // Slot pins
    input  wire logic                    I_SEAT_DETECT_A_N,
    input  wire logic                    I_SEAT_DETECT_B_N,
    input  wire logic                    I_BATTERY_LOW_N,
    output logic                         O_POWER_ON,
    output logic                         O_SLOT_RESET_N,
    output logic                         O_REGION0_SELECT_N,
    output logic                         O_REGION1_SELECT_N,
    output logic                         O_READ_STROBE_N,
    output logic                         O_WRITE_STROBE_N,
    output logic [`ESMB_ADDR_W-1:0]      O_ADDR,
    input  wire logic [`ESMB_DATA_W-1:0] I_DATA,
    output logic [`ESMB_DATA_W-1:0]      O_DATA,
    output logic                         O_DATA_OE_N
);
    localparam logic [7:0] SETUP_C = 8'(`ESMB_ADDR_SETUP_CYC);
    localparam logic [7:0] STRB_C  = 8'(`ESMB_STROBE_CYC);
    localparam logic [7:0] LEAD_C  = 8'(`ESMB_WE_LEAD_CYC);
    localparam logic [7:0] HOLD_C  = 8'(`ESMB_HOLD_CYC);

    esmb_pkg::esmb_state_t state_reg;    // Sequencer state
    esmb_pkg::esmb_state_t state_next;
    logic [7:0]            cnt_reg;      // Phase counter
    logic [7:0]            cnt_next;
    logic                  wr_reg;       // Current access is a write
    logic                  rgn_reg;      // Current region
    logic [`ESMB_ADDR_W-1:0] addr_reg;   // Held address
    logic [`ESMB_DATA_W-1:0] wdata_reg;  // Held write data
    logic [`ESMB_DATA_W-1:0] rdata_reg;  // Captured read data
    logic                  rsp_reg;      // Response pulse
    logic [1:0]            sda_sync;     // Seat detect A synchroniser
    logic [1:0]            sdb_sync;     // Seat detect B synchroniser
    logic [1:0]            bat_sync;     // Battery low synchroniser
    logic [`ESMB_DATA_W-1:0] d_s1_reg;   // Data bus first stage
    logic [`ESMB_DATA_W-1:0] d_s2_reg;   // Data bus second stage
    logic                  seated;       // Both seats low, battery fine
    logic                  ready;        // Slot out of reset
    logic                  phase_done;   // Counter reached its phase end
    logic [7:0]            phase_len;    // Length of current phase
    logic                  sel_on;       // Select asserted
    logic                  rd_on;        // Read strobe asserted
    logic                  wr_on;        // Write strobe asserted
    logic                  drv_on;       // Host drives data

    // Low battery electrically removes the module, same as unseating
    assign seated = !sda_sync[1] && !sdb_sync[1] && bat_sync[1];

    esmb_power #(
        .RESET_HOLD_CYC (RESET_HOLD_CYC)
    ) u_power (
        .i_ref_clk      (I_REF_CLK),
        .i_srst         (I_SRST),
        .i_seated       (seated),
        .i_sw_reset     (I_SW_RESET),
        .o_power_on     (O_POWER_ON),
        .o_slot_reset_n (O_SLOT_RESET_N),
        .o_ready        (ready)
    );

    // Phase lengths; strobe phase covers module data access time
    assign phase_len = (state_reg == esmb_pkg::ESMB_SETUP) ? SETUP_C :
                       (state_reg == esmb_pkg::ESMB_STRB)  ? STRB_C  :
                       (state_reg == esmb_pkg::ESMB_LEAD)  ? LEAD_C  : HOLD_C;
    assign phase_done = (cnt_reg == phase_len - 8'h01);

    // Sequencer: setup, strobe, write lead-out, hold
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = phase_done ? 8'h00 : cnt_reg + 8'h01;
        case (state_reg)
            esmb_pkg::ESMB_IDLE:
            begin
                cnt_next = 8'h00;
                if (I_REQ_VALID && ready)
                    state_next = esmb_pkg::ESMB_SETUP;
            end
            esmb_pkg::ESMB_SETUP:
                if (phase_done)
                    state_next = esmb_pkg::ESMB_STRB;
            esmb_pkg::ESMB_STRB:
                if (phase_done)
                    state_next = wr_reg ? esmb_pkg::ESMB_LEAD : esmb_pkg::ESMB_HOLD;
            esmb_pkg::ESMB_LEAD:
                if (phase_done)
                    state_next = esmb_pkg::ESMB_HOLD;
            esmb_pkg::ESMB_HOLD:
                if (phase_done)
                    state_next = esmb_pkg::ESMB_IDLE;
            default:
                state_next = esmb_pkg::ESMB_IDLE;
        endcase
        // Slot reset aborts any access in flight
        if (!ready)
            state_next = esmb_pkg::ESMB_IDLE;
    end

    // Pin decode; select covers strobe through lead, strobes only the strobe phase
    assign sel_on = (state_reg == esmb_pkg::ESMB_STRB) || (state_reg == esmb_pkg::ESMB_LEAD);
    assign rd_on  = (state_reg == esmb_pkg::ESMB_STRB) && !wr_reg;
    assign wr_on  = (state_reg == esmb_pkg::ESMB_STRB) && wr_reg;
    // Data driven from setup through hold in a write, never in a read
    assign drv_on = wr_reg && (state_reg != esmb_pkg::ESMB_IDLE);

    // Synchronisers and held bus values
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            sda_sync <= 2'h3;
            sdb_sync <= 2'h3;
            bat_sync <= 2'h0;
            d_s1_reg <= '0;
            d_s2_reg <= '0;
        end
        else
        begin
            sda_sync <= {sda_sync[0], I_SEAT_DETECT_A_N};
            sdb_sync <= {sdb_sync[0], I_SEAT_DETECT_B_N};
            bat_sync <= {bat_sync[0], I_BATTERY_LOW_N};
            d_s1_reg <= I_DATA;
            d_s2_reg <= d_s1_reg;
        end
    end

    // Sequencer registers and request capture
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            state_reg <= esmb_pkg::ESMB_IDLE;
            cnt_reg   <= 8'h00;
            wr_reg    <= 1'b0;
            rgn_reg   <= 1'b0;
            addr_reg  <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            rsp_reg   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            rsp_reg   <= 1'b0;
            // Address and data latched once, stable for the whole cycle
            if (O_REQ_READY && I_REQ_VALID)
            begin
                wr_reg    <= I_REQ_WRITE;
                rgn_reg   <= I_REQ_REGION;
                addr_reg  <= I_REQ_ADDR;
                wdata_reg <= I_REQ_WDATA;
            end
            // Read data taken at the last strobe cycle while the module drives;
            // once select rises the module may let the bus go
            if (state_reg == esmb_pkg::ESMB_STRB && phase_done && !wr_reg)
                rdata_reg <= d_s2_reg;
            // Response closes the access once the hold phase is over
            if (state_reg == esmb_pkg::ESMB_HOLD && phase_done)
                rsp_reg <= 1'b1;
        end
    end

    // Outputs
    assign O_REQ_READY        = (state_reg == esmb_pkg::ESMB_IDLE) && ready;
    assign O_RSP_VALID        = rsp_reg;
    assign O_RSP_RDATA        = rdata_reg;
    assign O_SLOT_READY       = ready;
    assign O_REGION0_SELECT_N = !(sel_on && !rgn_reg);
    assign O_REGION1_SELECT_N = !(sel_on && rgn_reg);
    assign O_READ_STROBE_N    = !rd_on;
    assign O_WRITE_STROBE_N   = !wr_on;
    assign O_ADDR             = addr_reg;
    assign O_DATA             = wdata_reg;
    assign O_DATA_OE_N        = !drv_on;

    // Assertions
    property p_one_select;
        @(posedge I_REF_CLK) disable iff (I_SRST)
        !(!O_REGION0_SELECT_N && !O_REGION1_SELECT_N);
    endproperty
    a_one_select: assert property (p_one_select) else $error("two selects");

    property p_read_no_we;
        @(posedge I_REF_CLK) disable iff (I_SRST)
        !O_READ_STROBE_N |-> O_WRITE_STROBE_N;
    endproperty
    a_read_no_we: assert property (p_read_no_we) else $error("we in read");

    property p_write_no_oe;
        @(posedge I_REF_CLK) disable iff (I_SRST)
        !O_WRITE_STROBE_N |-> O_READ_STROBE_N;
    endproperty
    a_write_no_oe: assert property (p_write_no_oe) else $error("oe in write");

    property p_we_before_sel;
        @(posedge I_REF_CLK) disable iff (I_SRST)
        $rose(O_WRITE_STROBE_N) |-> (!O_REGION0_SELECT_N || !O_REGION1_SELECT_N)[*6];
    endproperty
    a_we_before_sel: assert property (p_we_before_sel) else $error("select fell early");

    property p_data_before_we;
        @(posedge I_REF_CLK) disable iff (I_SRST)
        $fell(O_WRITE_STROBE_N) |-> $past(!O_DATA_OE_N, 14);
    endproperty
    a_data_before_we: assert property (p_data_before_we) else $error("data late");

    property p_addr_stable;
        @(posedge I_REF_CLK) disable iff (I_SRST)
        !O_READ_STROBE_N |-> $stable(O_ADDR);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("addr moved");

    property p_no_drive_read;
        @(posedge I_REF_CLK) disable iff (I_SRST)
        !O_READ_STROBE_N |-> O_DATA_OE_N;
    endproperty
    a_no_drive_read: assert property (p_no_drive_read) else $error("contention");

    property p_reset_no_access;
        @(posedge I_REF_CLK) disable iff (I_SRST)
        !O_SLOT_RESET_N |=> O_REGION0_SELECT_N && O_REGION1_SELECT_N;
    endproperty
    a_reset_no_access: assert property (p_reset_no_access) else $error("access in reset");

    property p_rd_len;
        @(posedge I_REF_CLK) disable iff (I_SRST)
        $fell(O_READ_STROBE_N) |-> !O_READ_STROBE_N[*8];
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe short");

    c_read:  cover property (@(posedge I_REF_CLK) $fell(O_READ_STROBE_N));
    c_write: cover property (@(posedge I_REF_CLK) $fell(O_WRITE_STROBE_N));
    c_rgn1:  cover property (@(posedge I_REF_CLK) $fell(O_REGION1_SELECT_N));
    c_rst:   cover property (@(posedge I_REF_CLK) $rose(O_SLOT_RESET_N));
endmodule

// File: test/esmb_slot_model.sv
// Purpose: Slot module model answering the host controller's bus
// Assumes: The bench resolves the shared data wire from the host enable alone
// Notes:   o_viol counts host cycles that break the bus rules
`timescale 1ns/1ps
`include "esmb_defs.svh"

module esmb_slot_model (
    // Host side pins
    input  wire logic                    i_power_on,
    input  wire logic                    i_slot_reset_n,
    input  wire logic                    i_region0_select_n,
    input  wire logic                    i_region1_select_n,
    input  wire logic                    i_read_strobe_n,
    input  wire logic                    i_write_strobe_n,
    input  wire logic [`ESMB_ADDR_W-1:0] i_addr,
    input  wire logic [`ESMB_DATA_W-1:0] i_data,
    // Bench control
    input  wire logic                    i_slow,
    // Module answer
    output logic [`ESMB_DATA_W-1:0]      o_data,
    output logic                         o_drive,
    output int                           o_viol
);
    logic [15:0] mem [32];  // Two regions of 16 words
    logic [15:0] last_val;  // Last driven word
    logic        late;      // Slow mode: data has arrived
    wire         live = i_power_on && i_slot_reset_n;
    wire         sel  = !i_region0_select_n || !i_region1_select_n;
    wire  [4:0]  idx  = {i_region0_select_n, i_addr[3:0]};
    wire         rd   = live && sel && !i_read_strobe_n;

    // Released wire shows the inverse, so a stale value never looks valid
    assign o_drive = rd && (!i_slow || late);
    assign o_data  = o_drive ? mem[idx] : ~last_val;
    initial o_viol = 0;
    initial last_val = 16'h0000;
    initial late = 1'b0;

    // Slow answer: data turns up 40 ns into the strobe
    always @(posedge rd)
    begin
        late = 1'b0;
        #40;
        late = rd;
    end
    always @(negedge rd) late = 1'b0;
    always @(posedge o_drive) last_val = mem[idx];

    // Power off or reset held: contents go back to a known pattern
    always @(live)
        if (!live)
            for (int i = 0; i < 32; i++) mem[i] = 16'h5a00 | 16'(i);

    // Whole word taken as the write strobe rises
    always @(posedge i_write_strobe_n)
        if (live && sel) mem[idx] = i_data;

    // Host misuse watch; the 1 ns wait lets same-step edges settle
    always @(i_read_strobe_n or i_write_strobe_n or i_region0_select_n or i_region1_select_n)
    begin
        if (!i_read_strobe_n && !i_write_strobe_n) o_viol++;
        if (!i_region0_select_n && !i_region1_select_n) o_viol++;
    end
    always @(posedge i_region0_select_n or posedge i_region1_select_n)
        if (!i_write_strobe_n) o_viol++;
    always @(i_addr) #1 if (sel) o_viol++;
    always @(i_data) #1 if (sel && !i_write_strobe_n) o_viol++;
endmodule

// File: test/expansion_slot_module_bus_tb_top.sv
// Purpose: Self-checking bench for the slot host controller
// Assumes: Inputs change on the falling clock edge
// Notes:   Reset window shortened to 20 cycles
`timescale 1ns/1ps
`include "esmb_defs.svh"

module expansion_slot_module_bus_tb_top;
    localparam int HOLD  = 20;    // Shortened slot reset window
    localparam int LIMIT = 20000; // Cycle ceiling for the run
    logic        clk, srst, vld, wr, rgn, swr, sa_n, sb_n, bat_n, slow;
    logic [23:0] adr, oadr;
    logic [15:0] wdat, hdat, mdat, rdat, q;
    logic        rdy, rsp, srdy, pwr, srn, cs0_n, cs1_n, rd_n, wr_n, oe_n, mdrv;
    wire  [15:0] bus = !oe_n ? hdat : mdat;  // Resolved data wire
    int          viol, n_errors, compares, cycles, lat;
    logic [23:0] ta [4] = '{24'h000000, 24'h00000f, 24'hfffff5, 24'h800003};
    logic [15:0] td [4] = '{16'hffff, 16'h0001, 16'h8000, 16'ha55a};

    esmb_host #(.RESET_HOLD_CYC(HOLD)) dut (
        .I_REF_CLK(clk), .I_SRST(srst), .I_REQ_VALID(vld), .I_REQ_WRITE(wr),
        .I_REQ_REGION(rgn), .I_REQ_ADDR(adr), .I_REQ_WDATA(wdat), .I_SW_RESET(swr),
        .O_REQ_READY(rdy), .O_RSP_VALID(rsp), .O_RSP_RDATA(rdat), .O_SLOT_READY(srdy),
        .I_SEAT_DETECT_A_N(sa_n), .I_SEAT_DETECT_B_N(sb_n), .I_BATTERY_LOW_N(bat_n),
        .O_POWER_ON(pwr), .O_SLOT_RESET_N(srn), .O_REGION0_SELECT_N(cs0_n),
        .O_REGION1_SELECT_N(cs1_n), .O_READ_STROBE_N(rd_n), .O_WRITE_STROBE_N(wr_n),
        .O_ADDR(oadr), .I_DATA(bus), .O_DATA(hdat), .O_DATA_OE_N(oe_n));
    esmb_slot_model mdl (
        .i_power_on(pwr), .i_slot_reset_n(srn), .i_region0_select_n(cs0_n),
        .i_region1_select_n(cs1_n), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
        .i_addr(oadr), .i_data(bus), .i_slow(slow), .o_data(mdat), .o_drive(mdrv),
        .o_viol(viol));

    // Clock, 4 ns period
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Contention watch and hang guard, looked at where the bus has settled
    always @(negedge clk)
    begin
        cycles++;
        chk({15'h0, !oe_n && mdrv}, 16'h0);
        if (cycles == LIMIT)
        begin
            n_errors++;
            give_verdict();
        end
    end

    // One bus access; returns read data and cycles from take to response
    task automatic access(input logic w, input logic r, input logic [23:0] a,
                          input logic [15:0] d);
        int n;
        vld = 1'b1;
        wr = w;
        rgn = r;
        adr = a;
        wdat = d;
        for (n = 0; !rdy && n < 500; n++) @(negedge clk);
        @(negedge clk);
        vld = 1'b0;
        for (lat = 1; !rsp && lat < 200; lat++) @(negedge clk);
        q = rdat;
    endtask

    task automatic wait_ready();
        int n;
        for (n = 0; !srdy && n < 200; n++) @(negedge clk);
        chk(srdy, 1'b1);
    endtask

    // Power only with both seats, reset held the full window
    task automatic t_power();
        int n;
        chk({pwr, srn, rdy, oe_n, cs0_n, cs1_n, rd_n, wr_n}, 16'h001f);
        sa_n = 1'b0;
        repeat (30) @(negedge clk);
        chk(pwr, 1'b0);
        sb_n = 1'b0;
        for (n = 0; !pwr && n < 20; n++) @(negedge clk);
        chk({pwr, srn}, 16'h0002);
        for (; !srn && n < 200; n++) @(negedge clk);
        chk(n >= HOLD && n <= HOLD + 10, 1'b1);
    endtask

    // Full words to both regions, then read back
    task automatic t_rw();
        for (int i = 0; i < 4; i++)
        begin
            access(1'b1, i[0], ta[i], td[i]);
            chk(lat[15:0], 16'd63);
        end
        for (int i = 0; i < 4; i++)
        begin
            access(1'b0, i[0], ta[i], 16'h0000);
            chk(q, td[i]);
            chk(lat[15:0], 16'd56);
        end
        access(1'b0, 1'b1, 24'h000007, 16'h0000);
        chk(q, 16'h5a17);
    endtask

    // Late data from the module, requests back to back
    task automatic t_slow();
        slow = 1'b1;
        for (int i = 3; i >= 0; i--)
        begin
            access(1'b0, i[0], ta[i], 16'h0000);
            chk(q, td[i]);
        end
        slow = 1'b0;
    endtask

    // Software reset in mid-read: no response, module starts over
    task automatic t_abort();
        int n;
        vld = 1'b1;
        wr = 1'b0;
        rgn = 1'b0;
        adr = ta[0];
        for (n = 0; !rdy && n < 500; n++) @(negedge clk);
        @(negedge clk);
        vld = 1'b0;
        repeat (20) @(negedge clk);
        swr = 1'b1;
        @(negedge clk);
        swr = 1'b0;
        repeat (2) @(negedge clk);
        chk(srn, 1'b0);
        for (n = 0; !rsp && n < 60; n++) @(negedge clk);
        chk(n[15:0], 16'd60);
        wait_ready();
        access(1'b0, 1'b0, ta[0], 16'h0000);
        chk(q, 16'h5a00);
    endtask

    // Low battery removes the module; it comes back fresh
    task automatic t_battery();
        bat_n = 1'b0;
        repeat (10) @(negedge clk);
        chk({pwr, srn}, 16'h0000);
        bat_n = 1'b1;
        wait_ready();
        access(1'b0, 1'b1, ta[1], 16'h0000);
        chk(q, 16'h5a1f);
    endtask

    initial
    begin
        n_errors = 0;
        compares = 0;
        cycles = 0;
        srst = 1'b1;
        vld = 1'b0;
        wr = 1'b0;
        rgn = 1'b0;
        swr = 1'b0;
        sa_n = 1'b1;
        sb_n = 1'b1;
        bat_n = 1'b1;
        slow = 1'b0;
        adr = 24'h000000;
        wdat = 16'h0000;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        t_power();
        t_rw();
        t_slow();
        t_abort();
        t_battery();
        chk(viol[15:0], 16'h0000);
        give_verdict();
    end
endmodule
